// ==== rtl/tbp_pkg.sv ====
// Purpose: Shared constants for the ten-bit pulse-width modulator block.
// Assumes: APB slave, 32-bit data, 8-bit byte address, clk at 10 MHz.
// Notes: Four channels, four selectable 8-bit time-base timers.

package tbp_pkg;

	// Structure
	localparam int TBP_NCH  = 4;
	localparam int TBP_NTMR = 4;

	// Register map, byte addresses
	localparam logic [7:0] ADDR_TSEL   = 8'h00;
	localparam logic [7:0] ADDR_PINDIR = 8'h04;
	localparam logic [1:0] REGION_MISC = 2'h0;
	localparam logic [1:0] REGION_CH   = 2'h1;
	localparam logic [1:0] REGION_TMR  = 2'h2;

	// Offsets within a channel block (base 0x40 + 0x10 * channel)
	localparam logic [3:0] SUB_CTRL = 4'h0;
	localparam logic [3:0] SUB_DCH  = 4'h4;
	localparam logic [3:0] SUB_DCL  = 4'h8;

	// Offsets within a timer block (base 0x80 + 0x10 * timer)
	localparam logic [3:0] SUB_TCON = 4'h0;
	localparam logic [3:0] SUB_PER  = 4'h4;
	localparam logic [3:0] SUB_CNT  = 4'h8;
	localparam logic [3:0] SUB_FLAG = 4'hc;

	// Field positions
	localparam int EN_BIT   = 7;
	localparam int OUT_BIT  = 5;
	localparam int POL_BIT  = 4;
	localparam int DCL_LSB  = 6;
	localparam int TON_BIT  = 7;
	localparam int PRESCALE_SELECT_LSB = 4;
	localparam int FLAG_BIT = 0;

	// Values after reset
	localparam logic [7:0] RST_TSEL   = 8'h00;
	localparam logic [3:0] RST_PINDIR = 4'hf;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [7:0] RST_DUTYH  = 8'h00;
	localparam logic [1:0] RST_DUTYL  = 2'h0;

	// Last extension count; four clock periods per timer increment before prescaling
	localparam logic [1:0] EXT_LAST = 2'h3;

endpackage : tbp_pkg

// ==== rtl/tbp_channel.sv ====
// Purpose: One modulator channel: duty buffer, compare and output stage.
// Assumes: wrap is a one-cycle pulse that never occurs during sleep.
// Notes: The level output comes from a flip-flop.
`timescale 1ns/1ps

module tbp_channel (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Time base of the selected timer as it stands after this edge
	input  wire logic       wrap,
	input  wire logic [9:0] tb,
	// Channel settings
	input  wire logic       en,
	input  wire logic       output_invert,
	input  wire logic [9:0] duty,
	// Output level after polarity
	output logic            level_ff
);
	logic [9:0] duty_buf_ff;
	logic       active_ff;
	logic       nxt_active;

	// Compare buffer loads only at period match, so a half-written duty
	// never reaches the comparator mid-period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			duty_buf_ff <= 10'h000;
		end else if (wrap) begin
			duty_buf_ff <= duty;
		end
	end

	// Active state: set at clear, cleared at match, idle when disabled
	always_comb begin
		nxt_active = active_ff;
		if (!en) begin
			nxt_active = 1'b0;
		end else if (wrap) begin
			nxt_active = (duty != 10'h000);
		end else if (tb == duty_buf_ff) begin
			nxt_active = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
		end
	end

	// Output stage; disabled channel rests at the inactive polarity level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_ff <= 1'b0;
		end else begin
			level_ff <= en ? (nxt_active ^ output_invert) : output_invert;
		end
	end

	property p_set_at_wrap;
		@(posedge clk) disable iff (!rst_n)
		(en && wrap && duty != 10'h000) |=> active_ff;
	endproperty
	a_set_at_wrap: assert property (p_set_at_wrap)
		else $error("channel not active after period clear");

	property p_zero_duty;
		@(posedge clk) disable iff (!rst_n)
		(wrap && duty == 10'h000) |=> !active_ff;
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("zero duty went active");

	property p_clear_match;
		@(posedge clk) disable iff (!rst_n)
		(!wrap && tb == duty_buf_ff) |=> !active_ff;
	endproperty
	a_clear_match: assert property (p_clear_match)
		else $error("output not cleared at duty match");

	property p_disabled;
		@(posedge clk) disable iff (!rst_n)
		!en |=> (level_ff == $past(output_invert) && !active_ff);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled channel not at inactive level");

	property p_polarity;
		@(posedge clk) disable iff (!rst_n)
		en |=> (level_ff == (active_ff ^ $past(output_invert)));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("output polarity wrong");

	property p_buffer;
		@(posedge clk) disable iff (!rst_n)
		!wrap |=> $stable(duty_buf_ff);
	endproperty
	a_buffer: assert property (p_buffer)
		else $error("duty buffer changed outside period match");

endmodule // tbp_channel

// ==== rtl/tbp_top.sv ====
// Purpose: Four-channel ten-bit modulator with four 8-bit time bases.
// Assumes: APB slave with zero wait states; sleep comes from same clock.
// Notes: Timer postscale bits are stored but steer nothing.
`timescale 1ns/1ps

module tbp_top (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// APB slave
	input  wire logic [7:0]                  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Power state
	input  wire logic                        sleep,
	// Levels for on-chip consumers
	output logic [tbp_pkg::TBP_NCH-1:0]      pwm_level,
	// Pins, enable low while driving
	output logic [tbp_pkg::TBP_NCH-1:0]      pin_out,
	output logic [tbp_pkg::TBP_NCH-1:0]      pin_oe_n
);
	import tbp_pkg::*;

	// Bus phases
	logic        apb_setup;
	logic        apb_access;
	logic        apb_wr;
	logic [1:0]  sel_idx;
	logic [3:0]  sub_off;
	logic [31:0] rd_val;
	logic [31:0] prdata_ff;

	// Global control
	logic [7:0]          tsel_ff;
	logic [TBP_NCH-1:0]  pin_direction_ctrl_ff;

	// Channel registers
	logic [TBP_NCH-1:0]  en_ff;
	logic [TBP_NCH-1:0]  output_invert_ff;
	logic [7:0]          duty_high_reg_ff [TBP_NCH];
	logic [1:0]          duty_low_reg_ff  [TBP_NCH];
	logic [TBP_NCH-1:0]  level;

	// Timer state
	logic [TBP_NTMR-1:0] tmr_on_ff;
	logic [2:0]          prescale_select_ff [TBP_NTMR];
	logic [3:0]          postscale_ff       [TBP_NTMR];
	logic [7:0]          period_match_value_ff [TBP_NTMR];
	logic [7:0]          shared_timer_count_ff [TBP_NTMR];
	logic [1:0]          ext_ff   [TBP_NTMR];
	logic [6:0]          pre_ff   [TBP_NTMR];
	logic [TBP_NTMR-1:0] timer_match_flag_ff;
	logic [TBP_NTMR-1:0] tmr_step;
	logic [TBP_NTMR-1:0] tmr_wrap;
	logic [9:0]          tmr_tb [TBP_NTMR];
	logic [9:0]          tmr_tb_nxt [TBP_NTMR];

	// Last prescaler count for a ratio of 2 to the power of the select
	function automatic logic [6:0] f_pre_last(input logic [2:0] ps);
		f_pre_last = 7'(({7'h00, 1'b1} << ps) - 8'h01);
	endfunction

	// Address decode, also used for the error answer
	function automatic logic f_mapped(input logic [7:0] a);
		f_mapped = 1'b0;
		case (a[7:6])
			REGION_MISC: f_mapped = (a == ADDR_TSEL) || (a == ADDR_PINDIR);
			REGION_CH:   f_mapped = (a[3:0] == SUB_CTRL) ||
				(a[3:0] == SUB_DCH) || (a[3:0] == SUB_DCL);
			REGION_TMR:  f_mapped = (a[1:0] == 2'h0);
			default:     f_mapped = 1'b0;
		endcase
	endfunction

	// Write strobe for one register of a region
	function automatic logic f_hit(input logic [7:0] a,
		input logic [1:0] region, input logic [1:0] idx,
		input logic [3:0] sub);
		f_hit = (a[7:6] == region) && (a[5:4] == idx) && (a[3:0] == sub);
	endfunction

	// Bus handshake: no wait states, error on unmapped words
	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_wr     = apb_access && pwrite;
	assign sel_idx    = paddr[5:4];
	assign sub_off    = paddr[3:0];
	assign pready     = 1'b1;
	assign pslverr    = apb_access && !f_mapped(paddr);
	assign prdata     = prdata_ff;

	// Source select and pin direction; pins float as inputs after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tsel_ff               <= RST_TSEL;
			pin_direction_ctrl_ff <= RST_PINDIR;
		end else if (apb_wr) begin
			if (paddr == ADDR_TSEL) begin
				tsel_ff <= pwdata[7:0];
			end
			if (paddr == ADDR_PINDIR) begin
				pin_direction_ctrl_ff <= pwdata[TBP_NCH-1:0];
			end
		end
	end

	// Pins carry the same level that internal consumers see
	assign pwm_level = level;
	assign pin_out   = level;
	assign pin_oe_n  = pin_direction_ctrl_ff;

	generate
		for (genvar t = 0; t < TBP_NTMR; t++) begin : g_tmr
			logic cnt_wr;
			assign cnt_wr = apb_wr && f_hit(paddr, REGION_TMR,
				2'(t), SUB_CNT);

			// Prescaler step; sleep and an idle timer freeze everything
			assign tmr_step[t] = tmr_on_ff[t] && !sleep &&
				(pre_ff[t] == f_pre_last(prescale_select_ff[t]));
			assign tmr_wrap[t] = tmr_step[t] && (ext_ff[t] == EXT_LAST) &&
				(shared_timer_count_ff[t] == period_match_value_ff[t]);
			// Timer count concatenated with the clock extension
			assign tmr_tb[t] = {shared_timer_count_ff[t], ext_ff[t]};
			// Time base one step ahead, so a channel acts on the step edge
			// and a timer frozen in sleep can never move a channel
			assign tmr_tb_nxt[t] = cnt_wr ? {pwdata[7:0], 2'h0} :
				tmr_wrap[t] ? 10'h000 :
				tmr_step[t] ? 10'(tmr_tb[t] + 10'h001) :
				tmr_tb[t];

			// Timer configuration registers
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					tmr_on_ff[t]             <= 1'b0;
					prescale_select_ff[t]    <= 3'h0;
					postscale_ff[t]          <= 4'h0;
					period_match_value_ff[t] <= RST_PERIOD;
				end else if (apb_wr) begin
					if (f_hit(paddr, REGION_TMR, 2'(t), SUB_TCON)) begin
						tmr_on_ff[t]          <= pwdata[TON_BIT];
						prescale_select_ff[t] <= pwdata[PRESCALE_SELECT_LSB+:3];
						postscale_ff[t]       <= pwdata[3:0];
					end
					if (f_hit(paddr, REGION_TMR, 2'(t), SUB_PER)) begin
						period_match_value_ff[t] <= pwdata[7:0];
					end
				end
			end

			// Prescaler runs on the system clock, so 1:1 steps every
			// clock and output frequency tracks clk directly
			always_ff @(posedge clk) begin
				if (!rst_n || cnt_wr) begin
					pre_ff[t] <= 7'h00;
				end else if (tmr_on_ff[t] && !sleep) begin
					pre_ff[t] <= tmr_step[t] ? 7'h00 :
						7'(pre_ff[t] + 7'h01);
				end
			end

			// Extension counts four prescaled clocks per timer increment
			always_ff @(posedge clk) begin
				if (!rst_n || cnt_wr) begin
					ext_ff[t] <= 2'h0;
				end else if (tmr_step[t]) begin
					ext_ff[t] <= 2'(ext_ff[t] + 2'h1);
				end
			end

			// Count clears on the increment after period match
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					shared_timer_count_ff[t] <= 8'h00;
				end else if (cnt_wr) begin
					shared_timer_count_ff[t] <= pwdata[7:0];
				end else if (tmr_wrap[t]) begin
					shared_timer_count_ff[t] <= 8'h00;
				end else if (tmr_step[t] && ext_ff[t] == EXT_LAST) begin
					shared_timer_count_ff[t] <=
						8'(shared_timer_count_ff[t] + 8'h01);
				end
			end

			// Match flag: write one to clear, a match in that cycle wins
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					timer_match_flag_ff[t] <= 1'b0;
				end else if (tmr_wrap[t]) begin
					timer_match_flag_ff[t] <= 1'b1;
				end else if (apb_wr && pwdata[FLAG_BIT] &&
					f_hit(paddr, REGION_TMR, 2'(t), SUB_FLAG)) begin
					timer_match_flag_ff[t] <= 1'b0;
				end
			end
		end

		for (genvar c = 0; c < TBP_NCH; c++) begin : g_ch
			logic [1:0] src;
			assign src = tsel_ff[2*c+:2];

			// Channel control and duty registers, writable at any time
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					en_ff[c]            <= 1'b0;
					output_invert_ff[c] <= 1'b0;
					duty_high_reg_ff[c] <= RST_DUTYH;
					duty_low_reg_ff[c]  <= RST_DUTYL;
				end else if (apb_wr) begin
					if (f_hit(paddr, REGION_CH, 2'(c), SUB_CTRL)) begin
						en_ff[c]            <= pwdata[EN_BIT];
						output_invert_ff[c] <= pwdata[POL_BIT];
					end
					if (f_hit(paddr, REGION_CH, 2'(c), SUB_DCH)) begin
						duty_high_reg_ff[c] <= pwdata[7:0];
					end
					if (f_hit(paddr, REGION_CH, 2'(c), SUB_DCL)) begin
						duty_low_reg_ff[c] <= pwdata[DCL_LSB+:2];
					end
				end
			end

			// Each channel takes period from its timer, duty of its own
			tbp_channel u_ch (
				.clk      (clk),
				.rst_n    (rst_n),
				.wrap     (tmr_wrap[src]),
				.tb       (tmr_tb_nxt[src]),
				.en       (en_ff[c]),
				.output_invert      (output_invert_ff[c]),
				.duty     ({duty_high_reg_ff[c], duty_low_reg_ff[c]}),
				.level_ff (level[c])
			);
		end
	endgenerate

	// Read mux; unimplemented bits read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr[7:6])
			REGION_MISC: begin
				if (paddr == ADDR_TSEL) begin
					rd_val[7:0] = tsel_ff;
				end else if (paddr == ADDR_PINDIR) begin
					rd_val[TBP_NCH-1:0] = pin_direction_ctrl_ff;
				end
			end
			REGION_CH: begin
				case (sub_off)
					SUB_CTRL: begin
						rd_val[EN_BIT]  = en_ff[sel_idx];
						rd_val[OUT_BIT] = level[sel_idx];
						rd_val[POL_BIT] = output_invert_ff[sel_idx];
					end
					SUB_DCH: rd_val[7:0] = duty_high_reg_ff[sel_idx];
					SUB_DCL: rd_val[DCL_LSB+:2] = duty_low_reg_ff[sel_idx];
					default: rd_val = 32'h0000_0000;
				endcase
			end
			REGION_TMR: begin
				case (sub_off)
					SUB_TCON: begin
						rd_val[TON_BIT]      = tmr_on_ff[sel_idx];
						rd_val[PRESCALE_SELECT_LSB+:3]  = prescale_select_ff[sel_idx];
						rd_val[3:0]          = postscale_ff[sel_idx];
					end
					SUB_PER:  rd_val[7:0] = period_match_value_ff[sel_idx];
					SUB_CNT:  rd_val[7:0] = shared_timer_count_ff[sel_idx];
					SUB_FLAG: rd_val[FLAG_BIT] = timer_match_flag_ff[sel_idx];
					default:  rd_val = 32'h0000_0000;
				endcase
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data captured in the setup cycle, held through the access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			prdata_ff <= rd_val;
		end
	end

	property p_cnt_clear;
		@(posedge clk) disable iff (!rst_n)
		(tmr_wrap[0] && !(apb_wr && paddr[7:6] == REGION_TMR))
			|=> (shared_timer_count_ff[0] == 8'h00 && ext_ff[0] == 2'h0);
	endproperty
	a_cnt_clear: assert property (p_cnt_clear)
		else $error("timer count not cleared after period match");

	property p_sleep_hold;
		@(posedge clk) disable iff (!rst_n)
		(sleep && !apb_wr) |=> ($stable(tmr_tb[0]) && $stable(level));
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("state moved during sleep");

	property p_flag_set;
		@(posedge clk) disable iff (!rst_n)
		tmr_wrap[1] |=> timer_match_flag_ff[1];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("match flag lost at period match");

	property p_pin_reset;
		@(posedge clk)
		!rst_n |=> (pin_oe_n == RST_PINDIR && en_ff == '0);
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("pins or enables not reset");

	property p_ext_step;
		@(posedge clk) disable iff (!rst_n)
		(!tmr_step[0] && !apb_wr) |=> $stable(ext_ff[0]);
	endproperty
	a_ext_step: assert property (p_ext_step)
		else $error("time base extension moved without a step");

	property p_tb_step;
		@(posedge clk) disable iff (!rst_n)
		(tmr_step[0] && !tmr_wrap[0] && !apb_wr)
			|=> (tmr_tb[0] == 10'($past(tmr_tb[0]) + 10'h001));
	endproperty
	a_tb_step: assert property (p_tb_step)
		else $error("time base did not advance by one step");

	property p_sleep_pre;
		@(posedge clk) disable iff (!rst_n)
		(sleep && !apb_wr) |=> $stable(pre_ff[0]);
	endproperty
	a_sleep_pre: assert property (p_sleep_pre)
		else $error("prescaler moved during sleep");

	property p_count_step;
		@(posedge clk) disable iff (!rst_n)
		(!(tmr_step[0] && ext_ff[0] == EXT_LAST) && !apb_wr)
			|=> $stable(shared_timer_count_ff[0]);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("timer count moved between extension wraps");

endmodule // tbp_top

// ==== dv/tbp_pin_model.sv ====
// Purpose: Pad seen by a board or an on-chip consumer of one modulator.
// Assumes: pin_oe_n low means the block drives the pad.
// Notes: An undriven pad floats; it shows the inverse of its last
//        driven level so a stale value can never pass for a real one.
`timescale 1ns/1ps

module tbp_pin_model (
	// Clock
	input  wire logic       clk,
	// Pin stage of the block
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe_n,
	// Resolved pad levels
	output logic      [3:0] pad
);
	logic [3:0] last_ff;

	// Remember what was last driven
	always_ff @(posedge clk) begin
		last_ff <= (pin_out & ~pin_oe_n) | (last_ff & pin_oe_n);
	end

	// Driven pads follow the block, released ones float
	assign pad = (pin_out & ~pin_oe_n) | (~last_ff & pin_oe_n);
endmodule // tbp_pin_model

// ==== dv/ten_bit_pwm_generator_tb.sv ====
// Purpose: Self-checking bench for the four-channel ten-bit modulator.
// Assumes: Zero-wait APB slave; levels observed on the falling edge.
// Notes: Pulse widths are measured per period against integer models.
`timescale 1ns/1ps
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	err_total++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module ten_bit_pwm_generator_tb;
	import tbp_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, sleep, pslverr, pready;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, r2;
	logic [3:0]  pwm_level, pin_out, pin_oe_n, pad;
	logic        mon_inv, prev, lv;
	int          err_total, compares, rises, last_hi, last_per, hi_c, per_c;
	int          mon_ch, tsel_m, pdir_m, p, ps, d;
	int          exp_q[$];

	tbp_top DUT (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep(sleep),
		.pwm_level(pwm_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
	tbp_pin_model u_pin (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pad(pad));

	// Free-running 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Period monitor: high and total cycles of each completed period
	always @(negedge clk) begin : mon_blk
		logic l;
		l = pwm_level[mon_ch] ^ mon_inv;
		if (l === 1'b1 && prev === 1'b0) begin
			last_hi = hi_c;
			last_per = per_c;
			rises++;
			hi_c = 0;
			per_c = 0;
		end
		per_c++;
		if (l === 1'b1) hi_c++;
		prev = l;
	end

	task automatic end_sim;
		if (err_total == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input int dt,
		output logic [31:0] rd, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input int dt);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, dt, x, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		logic e;
		apb(1'b0, a, 0, x, e);
	endtask

	// Register defaults and idle pins after any reset
	task automatic chk_rst;
		tsel_m = 0;
		pdir_m = 15;
		rd(ADDR_TSEL, r); `chk("tsel", 32'h0, r)
		rd(ADDR_PINDIR, r); `chk("pindir", 32'hf, r)
		for (int i = 0; i < 4; i++) begin
			rd(8'(64 + 16 * i), r); `chk("ctrl", 32'h0, r)
			rd(8'(132 + 16 * i), r); `chk("period", 32'hff, r)
		end
		`chk("oe_n", 4'hf, pin_oe_n)
		`chk("level", 4'h0, pwm_level)
	endtask

	// Setup in the order that gives a clean first cycle
	task automatic cfg(input int c, t, pp, pin_route_select, dd, output_invert);
		logic [7:0] ca, ta;
		logic [31:0] fl;
		int k;
		ca = 8'(64 + 16 * c);
		ta = 8'(128 + 16 * t);
		pdir_m[c] = 1; wr(ADDR_PINDIR, pdir_m);
		wr(ca, 0);
		wr(ta + 8'h04, pp);
		wr(ca + 8'h04, dd >> 2);
		wr(ca + 8'h08, (dd & 3) << 6);
		wr(ta + 8'h0c, 1);
		wr(ta, 128 | (pin_route_select << 4));
		wr(ta + 8'h08, 0);
		// Wait for the first period match before routing the pin
		k = 0;
		do begin
			rd(ta + 8'h0c, fl);
			k++;
		end while (fl[FLAG_BIT] !== 1'b1 && k < 200);
		`chk("flag", 1'b1, fl[FLAG_BIT])
		tsel_m[2*c+:2] = t; wr(ADDR_TSEL, tsel_m);
		pdir_m[c] = 0; wr(ADDR_PINDIR, pdir_m);
		wr(ca, 128 | (output_invert << 4));
	endtask

	task automatic wait_rise;
		int r0, n;
		r0 = rises;
		n = 0;
		while (rises == r0 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) err_total++;
	endtask

	// Measure one full period and compare with the integer model
	task automatic meas(input int c, inv, dd, s, pp);
		mon_ch = c;
		mon_inv = inv[0];
		// A switch of channel must not pass for a rising edge
		prev = 1'b1;
		wait_rise;
		wait_rise;
		`chk("high", dd * s, last_hi)
		`chk("period", (pp + 1) * 4 * s, last_per)
		`chk("pad", pwm_level[c], pad[c])
	endtask

	task automatic stuck(input int c, input logic v);
		int bad;
		bad = 0;
		repeat (40) begin
			@(negedge clk);
			if (pwm_level[c] !== v) bad++;
		end
		`chk("steady", 0, bad)
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		end_sim;
	end

	initial begin
		logic e;
		{psel, penable, pwrite, sleep, rst_n, prev, mon_inv} = 7'h0;
		paddr = 8'h00; pwdata = 32'h0; mon_ch = 0;
		void'($urandom(32'hc081a3f4));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_rst;
		// Unmapped address is refused, misaligned address reads back zero
		exp_q.delete();
		apb(1'b0, 8'hc0, 0, r, e); `chk("err", 1'b1, e)
		apb(1'b0, 8'h42, 0, r, e); `chk("err_rd", 32'h0, r)
		// Disabled inverted channel idles high
		wr(8'h60, 32'h10);
		repeat (3) @(posedge clk);
		@(negedge clk); `chk("idle", 1'b1, pwm_level[2])
		rd(8'h60, r); `chk("out_rb", 32'h30, r)
		// Random periods, duties and prescales over every timer source
		for (int i = 0; i < 4; i++) begin
			p = 3 + $urandom % 13;
			ps = $urandom % 3;
			d = 1 + $urandom % (4 * p + 2);
			cfg(i, 3 - i, p, ps, d, i % 2);
			meas(i, i % 2, d, 1 << ps, p);
		end
		// Duty change lands only at the next period match
		cfg(0, 0, 7, 0, 30, 0);
		meas(0, 0, 30, 1, 7);
		wr(8'h44, 0);
		wr(8'h48, 32'h40);
		exp_q.push_back(30);
		exp_q.push_back(1);
		repeat (2) begin
			wait_rise; `chk("dbuf", exp_q.pop_front(), last_hi)
		end
		// Zero duty stays inactive, overlong duty stays active
		cfg(1, 2, 3, 0, 0, 0);
		repeat (20) @(posedge clk);
		stuck(1, 1'b0);
		rd(8'h50, r); `chk("out_lo", 32'h80, r)
		wr(8'h54, 4);
		repeat (40) @(posedge clk);
		stuck(1, 1'b1);
		rd(8'h50, r); `chk("out_hi", 32'ha0, r)
		// Sleep freezes count and level, counting then resumes
		mon_ch = 0;
		mon_inv = 1'b0;
		wait_rise;
		@(posedge clk);
		sleep <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h88, r);
		lv = pwm_level[0];
		stuck(0, lv);
		rd(8'h88, r2);
		`chk("count", r, r2)
		@(posedge clk);
		sleep <= 1'b0;
		meas(0, 0, 1, 1, 7);
		// Reset in mid-run restores defaults
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_rst;
		end_sim;
	end
endmodule // ten_bit_pwm_generator_tb
